// File: core/sec_mem.sv
// Byte array: write port on the system clock, registered read port on the link clock
`timescale 1ns/1ps
module sec_mem #(
    parameter int AW = 13
) (
    // Clocks
    input  wire logic  wclk_i,
    input  wire logic  rclk_i,
    // Array access
    sec_mem_if.mem     mem_io
);

    logic [7:0] arr [2**AW];

    always_ff @(posedge wclk_i)
    begin
        if (mem_io.wr_en)
        begin
            arr[mem_io.wr_addr] <= mem_io.wr_data;
        end
    end

    always_ff @(posedge rclk_i)
    begin
        if (mem_io.rd_en)
        begin
            mem_io.rd_data <= arr[mem_io.rd_addr];
        end
    end

endmodule : sec_mem

// File: core/sec_top.sv
// Serial memory command engine: link shifter, decoder, status and programming control
//
// Overview of operation
// [RULE1] Shift opcode into 8-bit register on rising clock
// [RULE2] Host keeps select low, pause high
// [RULE3] All fields move most significant bit first
// [RULE4] First bit taken after select falls
// [RULE5] Pause freezes and resumes at same bit
// [RULE6] Decode array read and array write
// [RULE7] Decode latch set and latch clear
// [RULE8] Decode status read and status write
// [RULE9] Read opcode, 16-bit address, then data out
// [RULE10] Read pointer advances per byte, unlimited
// [RULE11] Read pointer wraps to zero past top
// [RULE12] Select high ends a read
// [RULE13] Latch sets only on exact eight-bit end
// [RULE14] Write opcode, address, then page data
// [RULE15] Page data wraps within aligned page
// [RULE16] Commit only if select rises after D0
// [RULE17] No array reads while programming
// [RULE18] Latch cleared at reset, clear, writes
// [RULE19] Latch cleared when programming finishes
// [RULE20] Status layout: guard, protect, latch, busy
// [RULE21] Busy flag high during programming only
// [RULE22] Latch commands work regardless of protection
// [RULE23] Protect bits kept, changed by status write
// [RULE24] Protect codes: none, quarter, half, all
// [RULE25] Guard pin low blocks status writes; code blocks them only while the guard enable bit (bit 7) is set
// [RULE26] Output high impedance while deselected
// [RULE27] Programming starts at select rise, bounded
// [RULE28] Unknown opcode ignored, output stays off
`timescale 1ns/1ps
`include "sec_params.svh"
module sec_top #(
    parameter int          ADDR_W      = `SEC_ADDR_W,
    parameter int          PAGE_W      = `SEC_PAGE_W,
    parameter int unsigned PROG_CYCLES = (`SEC_TWC_US * `SEC_CLK_KHZ) / 1000
) (
    // System clock and reset
    input  wire logic  CLK_SYS_I,
    input  wire logic  SRST_I,
    // Serial link
    input  wire logic  SCK_I,
    input  wire logic  CS_N_I,
    input  wire logic  SI_I,
    input  wire logic  PAUSE_N_I,
    input  wire logic  GUARD_N_I,
    output      logic  SO_O,
    output      logic  SO_OE_O
);
    import sec_pkg::*;

    localparam int TW = $clog2(PROG_CYCLES + 1);

    function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        unique case (bp)
            2'h0: is_prot = 1'b0;
            2'h1: is_prot = &a[ADDR_W-1 -: 2];
            2'h2: is_prot = a[ADDR_W-1];
            2'h3: is_prot = 1'b1;
        endcase
    endfunction : is_prot

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain

    logic [2:0]              bit_q;
    sec_phase_e              ph_q;
    sec_phase_e              ph_d;
    logic [7:0]              sh_q;
    logic                    op_rd_q;
    logic [ADDR_W-1:0]       ptr_q;
    logic [ADDR_W-1:0]       rd_addr_d;
    logic [7:0]              pb_q [2**PAGE_W];
    logic [2**PAGE_W-1:0]    pb_v_q;
    sec_commit_e             cm_q;
    sec_commit_e             cm_d;
    logic [7:0]              sr_new_q;
    logic [7:0]              sr_s1_q;
    logic [7:0]              sr_s2_q;
    logic [7:0]              tx_q;
    logic                    so_en_q;
    logic                    step;
    logic                    byte_done;
    logic [7:0]              byte_w;
    logic                    busy_s;
    logic [7:0]              sec_status;

    sec_mem_if #(.AW(ADDR_W)) mem_io ();

    assign step      = !CS_N_I && PAUSE_N_I;
    assign byte_w    = {sh_q[6:0], SI_I};                                          // [RULE3]
    assign byte_done = (bit_q == 3'h7);
    assign busy_s    = sr_s2_q[`SEC_SR_BUSY];

    // Decode of the next phase at each byte boundary
    always_comb
    begin
        ph_d = ph_q;
        unique case (ph_q)
            PH_OP:
            begin
                unique case (byte_w)                                               // [RULE6] [RULE8]
                    `SEC_OP_READ, `SEC_OP_WRITE: ph_d = PH_ADH;
                    `SEC_OP_STAT_RD:             ph_d = PH_SRD;
                    `SEC_OP_STAT_WR:             ph_d = PH_SWR;
                    default:                     ph_d = PH_IGN;                    // [RULE28]
                endcase
            end
            PH_ADH: ph_d = PH_ADL;
            PH_ADL: ph_d = op_rd_q ? (busy_s ? PH_IGN : PH_RD) : PH_WR;            // [RULE17]
            PH_RD:  ph_d = PH_RD;
            PH_WR:  ph_d = PH_WR;
            PH_SRD: ph_d = PH_SRD;
            PH_SWR: ph_d = PH_IGN;
            PH_IGN: ph_d = PH_IGN;
        endcase
    end

    // Commit candidate: valid only if no further bit follows the boundary
    always_comb
    begin
        cm_d = CM_NONE;
        if (byte_done)
        begin
            unique case (ph_q)
                PH_OP:  cm_d = (byte_w == `SEC_OP_LATCH_SET) ? CM_SET :            // [RULE7] [RULE13]
                               (byte_w == `SEC_OP_LATCH_CLR) ? CM_CLR : CM_NONE;
                PH_SWR: cm_d = CM_STWR;
                PH_WR:  cm_d = CM_WRITE;                                           // [RULE16]
                default: cm_d = CM_NONE;
            endcase
        end
    end

    assign rd_addr_d = (ph_q == PH_ADL) ? {ptr_q[ADDR_W-1:8], byte_w} : ptr_q + 1'b1; // [RULE11]

    // Frame position, cleared by the select pin itself since the link clock stops
    always_ff @(posedge SCK_I or posedge CS_N_I)
    begin
        if (CS_N_I)
        begin
            bit_q <= 3'h0;                                                         // [RULE4] [RULE12]
            ph_q  <= PH_OP;
        end
        else if (PAUSE_N_I)                                                        // [RULE5]
        begin
            bit_q <= bit_q + 3'h1;                                                 // [RULE1]
            if (byte_done)
            begin
                ph_q <= ph_d;
            end
        end
    end

    // Status synchronised into the link domain, resampled at every link clock rise within a frame
    always_ff @(posedge SCK_I or posedge CS_N_I)
    begin
        if (CS_N_I)
        begin
            sr_s1_q <= `SEC_SR_SYNC_RST;
            sr_s2_q <= `SEC_SR_SYNC_RST;
        end
        else
        begin
            sr_s1_q <= sec_status;
            sr_s2_q <= sr_s1_q;
        end
    end

    // Shifter, pointer and page latches; held after the frame for the system side
    always_ff @(posedge SCK_I)
    begin
        if (step)
        begin
            sh_q <= byte_w;                                                        // [RULE1]
            cm_q <= cm_d;
            if (byte_done)
            begin
                unique case (ph_q)
                    PH_OP:  op_rd_q <= (byte_w == `SEC_OP_READ);
                    PH_ADH: ptr_q[ADDR_W-1:8] <= byte_w[ADDR_W-9:0];               // [RULE9]
                    PH_ADL:
                    begin
                        ptr_q <= rd_addr_d;
                        if (!busy_s)
                        begin
                            pb_v_q <= '0;
                        end
                    end
                    PH_RD:  ptr_q <= rd_addr_d;                                    // [RULE10]
                    PH_WR:
                    begin
                        if (!busy_s)                                               // [RULE14]
                        begin
                            pb_q[ptr_q[PAGE_W-1:0]]   <= byte_w;
                            pb_v_q[ptr_q[PAGE_W-1:0]] <= 1'b1;
                        end
                        ptr_q[PAGE_W-1:0] <= ptr_q[PAGE_W-1:0] + 1'b1;             // [RULE15]
                    end
                    PH_SWR: sr_new_q <= byte_w;
                    default: ;
                endcase
            end
        end
    end

    assign mem_io.rd_en   = step && byte_done && (ph_q == PH_ADL || ph_q == PH_RD);
    assign mem_io.rd_addr = rd_addr_d;

    // Output shifter moves on the falling edge so data is settled for the next rise
    always_ff @(negedge SCK_I or posedge CS_N_I)
    begin
        if (CS_N_I)
        begin
            tx_q    <= 8'h00;
            so_en_q <= 1'b0;
        end
        else if (PAUSE_N_I)
        begin
            if (bit_q == 3'h0 && (ph_q == PH_RD || ph_q == PH_SRD))
            begin
                tx_q    <= (ph_q == PH_RD) ? mem_io.rd_data : sr_s2_q;             // [RULE9] [RULE8]
                so_en_q <= 1'b1;
            end
            else
            begin
                tx_q <= {tx_q[6:0], 1'b0};                                         // [RULE3]
            end
        end
    end

    assign SO_O    = tx_q[7];
    assign SO_OE_O = so_en_q && !CS_N_I && PAUSE_N_I;                              // [RULE26]

    ////////////////////////////////////////////////////////////////////////////////
    // System domain

    logic                    cs_s1_q;
    logic                    cs_s2_q;
    logic                    cs_s3_q;
    logic                    gd_s1_q;
    logic                    gd_s2_q;
    logic                    cs_rise;
    logic                    guard;
    logic                    wel_q;
    logic                    guard_pin_enable_q;
    logic [1:0]              bp_q;
    sec_prog_e               pg_q;
    logic [TW-1:0]           tmr_q;
    logic [PAGE_W-1:0]       idx_q;
    logic [ADDR_W-PAGE_W-1:0] pbase_q;
    logic                    busy;
    logic                    start_wr;
    logic                    start_sr;
    logic [ADDR_W-1:0]       cp_addr;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            gd_s1_q <= 1'b1;
            gd_s2_q <= 1'b1;
        end
        else
        begin
            cs_s1_q <= CS_N_I;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            gd_s1_q <= GUARD_N_I;
            gd_s2_q <= gd_s1_q;
        end
    end

    // Link registers are read only here, after select rose and the link clock is idle
    assign cs_rise  = cs_s2_q && !cs_s3_q;
    assign busy     = (pg_q != PG_IDLE);                                           // [RULE21]
    assign guard    = guard_pin_enable_q && !gd_s2_q;                                          // [RULE25]
    assign start_wr = cs_rise && !busy && wel_q && (cm_q == CM_WRITE);             // [RULE16]
    assign start_sr = cs_rise && !busy && wel_q && (cm_q == CM_STWR) && !guard;    // [RULE25]
    assign cp_addr  = {pbase_q, idx_q};

    assign sec_status = {guard_pin_enable_q, 3'h0, bp_q, wel_q, busy};                         // [RULE20]

    // Write latch
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            wel_q <= 1'b0;                                                         // [RULE18]
        end
        else if (pg_q == PG_WAIT && tmr_q == '0)
        begin
            wel_q <= 1'b0;                                                         // [RULE19]
        end
        else if (cs_rise && !busy && cm_q == CM_SET)
        begin
            wel_q <= 1'b1;                                                         // [RULE22]
        end
        else if (cs_rise && !busy && cm_q == CM_CLR)
        begin
            wel_q <= 1'b0;                                                         // [RULE22]
        end
    end

    // Nonvolatile status bits
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            {guard_pin_enable_q, bp_q} <= `SEC_NV_RST;
        end
        else if (start_sr)
        begin
            guard_pin_enable_q <= sr_new_q[`SEC_SR_GUARD_EN];                                  // [RULE23]
            bp_q   <= sr_new_q[`SEC_SR_BP_HI:`SEC_SR_BP_LO];
        end
    end

    // Programming cycle: page copy for array writes (status writes skip it), then wait out the full cycle time
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            pg_q    <= PG_IDLE;
            tmr_q   <= '0;
            idx_q   <= '0;
            pbase_q <= '0;
        end
        else
        begin
            unique case (pg_q)
                PG_IDLE:
                begin
                    if (start_wr || start_sr)
                    begin
                        pg_q    <= start_wr ? PG_COPY : PG_WAIT;                   // [RULE27]
                        tmr_q   <= TW'(PROG_CYCLES - 1);
                        idx_q   <= '0;
                        pbase_q <= ptr_q[ADDR_W-1:PAGE_W];
                    end
                end
                PG_COPY:
                begin
                    tmr_q <= tmr_q - 1'b1;
                    idx_q <= idx_q + 1'b1;
                    if (&idx_q)
                    begin
                        pg_q <= PG_WAIT;
                    end
                end
                PG_WAIT:
                begin
                    if (tmr_q == '0)
                    begin
                        pg_q <= PG_IDLE;
                    end
                    else
                    begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                default: pg_q <= PG_IDLE;
            endcase
        end
    end

    // Protected locations of the page are skipped, the rest of the page is kept
    assign mem_io.wr_en   = (pg_q == PG_COPY) && pb_v_q[idx_q] && !is_prot(cp_addr, bp_q); // [RULE24]
    assign mem_io.wr_addr = cp_addr;
    assign mem_io.wr_data = pb_q[idx_q];

    sec_mem #(.AW(ADDR_W)) sec_mem_inst (
        .wclk_i (CLK_SYS_I),
        .rclk_i (SCK_I),
        .mem_io (mem_io)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [TW:0] busy_cnt_q;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I || !busy)
        begin
            busy_cnt_q <= '0;
        end
        else
        begin
            busy_cnt_q <= busy_cnt_q + 1'b1;
        end
    end

    prog_bound_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)      // [RULE27]
        busy_cnt_q <= (TW+1)'(PROG_CYCLES)) else $error("programming cycle too long");
    prog_start_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)      // [RULE16]
        cs_rise && !busy && wel_q && cm_q == CM_WRITE |=> busy) else $error("write not started");
    no_commit_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)       // [RULE13]
        cs_rise && !busy && cm_q == CM_NONE |=> !busy && $stable(wel_q))
        else $error("aborted sequence changed state");
    latch_end_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)       // [RULE19]
        $fell(busy) |-> !wel_q) else $error("latch kept after programming");
    latch_set_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)       // [RULE22]
        cs_rise && !busy && cm_q == CM_SET |=> wel_q ##1 wel_q) else $error("latch not set");
    latch_clr_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)       // [RULE7]
        cs_rise && !busy && cm_q == CM_CLR |=> !wel_q) else $error("latch not cleared");
    guard_blk_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)       // [RULE25]
        cs_rise && cm_q == CM_STWR && guard |=> $stable({guard_pin_enable_q, bp_q}))
        else $error("guarded status changed");
    nv_source_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)       // [RULE23]
        $changed(bp_q) |-> $past(cs_rise && cm_q == CM_STWR)) else $error("protect bits moved");
    prot_skip_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)       // [RULE24]
        mem_io.wr_en |-> !is_prot(mem_io.wr_addr, bp_q)) else $error("protected byte written");
    pause_hold_a: assert property (@(posedge SCK_I) disable iff (CS_N_I)          // [RULE5]
        !PAUSE_N_I |=> $stable(bit_q) && $stable(ph_q)) else $error("pause lost position");
    read_wrap_a: assert property (@(posedge SCK_I) disable iff (CS_N_I)           // [RULE11]
        PAUSE_N_I && byte_done && ph_q == PH_RD |=> ptr_q == ADDR_W'($past(ptr_q) + 1'b1))
        else $error("read pointer did not advance");
    ign_quiet_a: assert property (@(negedge SCK_I) disable iff (CS_N_I)           // [RULE28]
        ph_q == PH_IGN |-> !so_en_q) else $error("output driven in ignored command");

    write_cv: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I) start_wr);
    stat_cv:  cover property (@(posedge CLK_SYS_I) disable iff (SRST_I) start_sr);
    guard_cv: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
        cs_rise && cm_q == CM_STWR && guard);
    wrap_cv:  cover property (@(posedge SCK_I) disable iff (CS_N_I)
        ph_q == PH_RD && ptr_q == '0);

endmodule : sec_top

// File: inc/sec_mem_if.sv
// Carrier between the command engine and its array memory
`timescale 1ns/1ps
interface sec_mem_if #(parameter int AW = 13);

    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [7:0]    rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_en, input rd_addr, output rd_data);

endinterface : sec_mem_if

// File: inc/sec_params.svh
// Constants of the serial memory command engine: opcodes, status layout, timing
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

// Opcodes
`define SEC_OP_READ      8'h03
`define SEC_OP_WRITE     8'h02
`define SEC_OP_LATCH_CLR 8'h04
`define SEC_OP_LATCH_SET 8'h06
`define SEC_OP_STAT_RD   8'h05
`define SEC_OP_STAT_WR   8'h01

// Status field positions
`define SEC_SR_GUARD_EN  7
`define SEC_SR_BP_HI     3
`define SEC_SR_BP_LO     2
`define SEC_SR_LATCH     1
`define SEC_SR_BUSY      0

// Reset values
`define SEC_NV_RST       3'h0
`define SEC_SR_SYNC_RST  8'h01

// Timing
`define SEC_TWC_US       6000
`define SEC_CLK_KHZ      10000

// Geometry
`define SEC_ADDR_W       13
`define SEC_PAGE_W       5

`endif

// File: inc/sec_pkg.sv
// Types shared by the serial memory command engine
package sec_pkg;

    typedef enum logic [2:0]
    {
        PH_OP  = 3'h0,
        PH_ADH = 3'h1,
        PH_ADL = 3'h3,
        PH_RD  = 3'h2,
        PH_WR  = 3'h6,
        PH_SRD = 3'h7,
        PH_SWR = 3'h5,
        PH_IGN = 3'h4
    } sec_phase_e;

    typedef enum logic [2:0]
    {
        CM_NONE  = 3'h0,
        CM_SET   = 3'h1,
        CM_CLR   = 3'h3,
        CM_STWR  = 3'h2,
        CM_WRITE = 3'h6
    } sec_commit_e;

    typedef enum logic [1:0]
    {
        PG_IDLE = 2'h0,
        PG_COPY = 2'h1,
        PG_WAIT = 2'h3
    } sec_prog_e;

endpackage : sec_pkg

// File: tb/sec_host.sv
// Host model: mode 0 bus master on the serial link of the engine
`timescale 1ns/1ps
module sec_host (
    // Link out
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    output logic      pause_n_o,
    // Link in
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    logic oe_any;
    logic hold_oe;
    initial
    begin
        sck_o     = 1'b0;
        cs_n_o    = 1'b0;
        si_o      = 1'b0;
        pause_n_o = 1'b1;
        oe_any    = 1'b0;
        hold_oe   = 1'b0;
        // A clean rising select edge clears the frame logic, which has no other reset
        #1;
        cs_n_o    = 1'b1;
    end
    // Select low for the whole frame; pause stays high except during a hold
    task sel();
        cs_n_o = 1'b0;
        oe_any = 1'b0;
        #40;
    endtask : sel
    // Gap covers the three system cycles the engine needs; clock stays low
    task desel();
        #40;
        cs_n_o = 1'b1;
        si_o   = ~si_o;
        #600;
    endtask : desel
    // Sends n bits MSB first, samples the output at each rise
    task xfer(input logic [7:0] tx, input int n, input int hold_at, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            if (i == hold_at)
            begin
                // Pause with clock low; junk pulses meanwhile must be ignored
                pause_n_o = 1'b0;
                for (int k = 0; k < 2; k++)
                begin
                    #32;
                    hold_oe = hold_oe | so_oe_i;
                    si_o    = ~si_o;
                    sck_o   = 1'b1;
                    #32;
                    sck_o = 1'b0;
                end
                pause_n_o = 1'b1;
            end
            si_o = tx[i];
            #32;
            sck_o  = 1'b1;
            rx[i]  = so_i;
            oe_any = oe_any | so_oe_i;
            #32;
            sck_o = 1'b0;
        end
    endtask : xfer
endmodule : sec_host

// File: tb/sec_top_tb_top.sv
// Self-checking bench of the serial memory command engine
`timescale 1ns/1ps
module sec_top_tb_top;
    logic        clk;
    logic        srst;
    logic        guard_n;
    logic        sck;
    logic        cs_n;
    logic        si;
    logic        pause_n;
    logic        so;
    logic        so_oe;
    logic [15:0] rx;
    int          bad_count;
    int          comparisons;
    int          cycles;
    // Latch command rows: opcode, trailing bits, expected status
    logic [23:0] rows [6] = '{24'h060002, 24'h040000, 24'h060300,
                              24'h060002, 24'hFF0002, 24'h040000};

    sec_top #(.PROG_CYCLES(200)) sec_top_inst (
        .CLK_SYS_I(clk), .SRST_I(srst), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
        .PAUSE_N_I(pause_n), .GUARD_N_I(guard_n), .SO_O(so), .SO_OE_O(so_oe));
    sec_host sec_host_inst (
        .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .pause_n_o(pause_n),
        .so_i(so), .so_oe_i(so_oe));

    initial
    begin
        clk = 1'b0;
    end
    always #50 clk = ~clk;

    task give_verdict();
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One frame: opcode, address bytes, data bytes (left aligned), trailing bits
    task frame(input logic [7:0] op, input logic [15:0] a, input int na,
               input logic [23:0] d, input int nd, input int tail, input int hold);
        logic [7:0] b;
        sec_host_inst.sel();
        sec_host_inst.xfer(op, 8, -1, b);
        for (int i = 0; i < na; i++)
            sec_host_inst.xfer(a[15 - 8 * i -: 8], 8, -1, b);
        for (int i = 0; i < nd; i++)
        begin
            sec_host_inst.xfer(d[23 - 8 * i -: 8], 8, (i == nd - 1) ? hold : -1, b);
            rx = {rx[7:0], b};
        end
        if (tail > 0)
            sec_host_inst.xfer(8'h55, tail, -1, b);
        sec_host_inst.desel();
    endtask : frame

    task stat(input logic [7:0] e);
        frame(8'h05, 16'h0000, 0, 24'h000000, 1, 0, -1);
        check({8'h00, rx[7:0]}, {8'h00, e});
    endtask : stat

    // Latch set in its own frame, then the write command
    task prog(input logic [7:0] op, input logic [15:0] a, input int na,
              input logic [23:0] d, input int nd, input int tail);
        frame(8'h06, 16'h0000, 0, 24'h000000, 0, 0, -1);
        frame(op, a, na, d, nd, tail, -1);
    endtask : prog

    // Programming lasts 200 system cycles, plus synchroniser margin
    task idle();
        repeat (260) @(posedge clk);
    endtask : idle

    initial
    begin
        srst        = 1'b1;
        guard_n     = 1'b1;
        rx          = 16'h0000;
        bad_count   = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        stat(8'h00);
        foreach (rows[r])
        begin
            frame(rows[r][23:16], 16'h0000, 0, 24'h000000, 0, rows[r][15:8], -1);
            check({15'h0, sec_host_inst.oe_any}, 16'h0000);
            stat(rows[r][7:0]);
        end
        prog(8'h02, 16'h003E, 2, 24'hA1A2A3, 3, 0);
        stat(8'h03);
        frame(8'h03, 16'h003E, 2, 24'h000000, 1, 0, -1);
        check({15'h0, sec_host_inst.oe_any}, 16'h0000);
        idle();
        stat(8'h00);
        frame(8'h03, 16'h003E, 2, 24'h000000, 2, 0, -1);
        check(rx, 16'hA1A2);
        check({15'h0, so_oe}, 16'h0000);
        frame(8'h03, 16'h0020, 2, 24'h000000, 1, 0, -1);
        check({8'h00, rx[7:0]}, 16'h00A3);
        // Select rises three bits after a data byte: nothing stored
        prog(8'h02, 16'h0020, 2, 24'h550000, 1, 3);
        idle();
        stat(8'h02);
        frame(8'h03, 16'h0020, 2, 24'h000000, 1, 0, -1);
        check({8'h00, rx[7:0]}, 16'h00A3);
        prog(8'h02, 16'h1FFF, 2, 24'h5A0000, 1, 0);
        idle();
        prog(8'h02, 16'h0000, 2, 24'hC30000, 1, 0);
        idle();
        frame(8'h03, 16'h1FFF, 2, 24'h000000, 2, 0, 4);
        check(rx, 16'h5AC3);
        check({15'h0, sec_host_inst.hold_oe}, 16'h0000);
        prog(8'h01, 16'h0000, 0, 24'hFC0000, 1, 0);
        idle();
        stat(8'h8C);
        prog(8'h02, 16'h0000, 2, 24'h110000, 1, 0);
        idle();
        frame(8'h03, 16'h0000, 2, 24'h000000, 1, 0, -1);
        check({8'h00, rx[7:0]}, 16'h00C3);
        @(negedge clk);
        guard_n = 1'b0;
        prog(8'h01, 16'h0000, 0, 24'h000000, 1, 0);
        idle();
        stat(8'h8E);
        @(negedge clk);
        guard_n = 1'b1;
        prog(8'h01, 16'h0000, 0, 24'h000000, 1, 0);
        idle();
        stat(8'h00);
        give_verdict();
    end
endmodule : sec_top_tb_top
